// ===== inc/pmm_pkg.sv
/*
  pmm_pkg: register map, key values, mode codes, timing counts and
  state types of the power mode manager.
  assumes a 200 MHz system clock and a 32-bit apb register bus.
*/
package pmm_pkg;
  // ***********************************************
  // register map
  // ***********************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_UNLOCK = 12'h004;
  localparam logic [11:0] OFS_CAUSE = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int BIT_LOW_PREC = 6;
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 2;
  localparam int BIT_CAUSE_SUPPLY = 0;
  localparam int BIT_ST_HALT = 0;
  localparam int BIT_ST_HIB = 1;
  localparam int BIT_ST_RUN = 2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  // ***********************************************
  // unlock keys and mode codes
  // ***********************************************
  localparam logic [15:0] KEY_FIRST = 16'h4859;
  localparam logic [15:0] KEY_SECOND = 16'hf27b;
  localparam logic [2:0] CODE_ACTIVE = 3'h0;
  localparam logic [2:0] CODE_HALT = 3'h3;
  localparam logic [2:0] CODE_HIB = 3'h5;
  // ***********************************************
  // timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int POR_HOLD_NS = 18000000;
  localparam int RESET_EXIT_NS = 1250000;
  localparam int POR_HOLD_CYCLES = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_EXIT_CYCLES = (RESET_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 23;
  // ***********************************************
  // sram clearing
  // ***********************************************
  localparam int SRAM_AW = 10;
  localparam int SRAM_DW = 39;
  localparam logic [SRAM_DW-1:0] SRAM_CLEAR = 39'h00_0000_0000;
  localparam logic [SRAM_AW-1:0] SRAM_LAST = 10'h3ff;
  // ***********************************************
  // state types
  // ***********************************************
  typedef enum logic [1:0] {PM_ACTIVE, PM_HALT, PM_HIBERNATE} pmm_power_type;
  typedef enum logic [1:0] {UL_LOCKED, UL_FIRST, UL_OPEN} pmm_unlock_type;
  typedef enum logic [1:0] {BT_HOLD, BT_INIT, BT_RUN} pmm_boot_type;
endpackage

// ===== verilog/pmm_delay_counter.sv
/*
  pmm_delay_counter: loadable down counter, pulses done on expiry.
  assumes a load is a single-cycle pulse from the boot sequencer.
*/
`timescale 1ns/10ps
module pmm_delay_counter
  import pmm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // control
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_load_value,
  // status
  output logic o_busy,
  output logic o_done
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  wire expiring = (count == {{(CNT_W-1){1'b0}}, 1'b1}) && !i_load;

  assign next_count = i_load ? i_load_value :
                      (count != '0) ? count - 1'b1 : count;
  assign o_busy = (count != '0);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      count <= '0;
      o_done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      o_done <= expiring;
    end
  end
endmodule // pmm_delay_counter

// ===== verilog/pmm_sram_clear.sv
/*
  pmm_sram_clear: sweeps every sram word once, writing zero data with
  matching zero check bits.
  assumes the sram takes one write per clock while the core is in reset.
*/
`timescale 1ns/10ps
module pmm_sram_clear
  import pmm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  // sram write port
  output logic o_we,
  output logic [SRAM_AW-1:0] o_addr,
  output logic [SRAM_DW-1:0] o_wdata
);
  wire last_word = o_we && (o_addr == SRAM_LAST);

  // all-zero word carries all-zero check bits, so no encoder needed
  assign o_wdata = SRAM_CLEAR;

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_we <= 1'b0;
      o_addr <= '0;
    end
    else if (i_start)
    begin
      o_we <= 1'b1;
      o_addr <= '0;
    end
    else if (o_we)
    begin
      o_we <= !last_word;
      o_addr <= o_addr + 1'b1;
    end
  end
endmodule // pmm_sram_clear

// ===== verilog/pmm_top.sv
/*
  pmm_top: always-on power mode manager with apb registers, key-protected
  mode selection, clock and power gating per mode, and the supply-start
  reset sequence with optional sram clearing.
  assumes the core reports its sleep and deep-sleep levels, and that the
  designated wake sources raise i_wake while the core clock is stopped.
*/
// Register access over APB was decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// (R1) mode code 000 selects active, 011 selects bus-clock-halt on next sleep.
// (R2) writing 0x5 to the mode register selects hibernate.
// (R3) software writes keys 0x4859 then 0xF27B before each mode write.
// (R4) reading the code returns the value last written, not current mode.
// (R5) bit 6 picks fast oscillator precision: 0 high, 1 low.
// (R6) software writes zero to reserved bits 7 and 5 to 3.
// (R7) mode register resets to 0x00: active, high precision.
// (R8) active mode gates no clock.
// (R9) core sleep happens in any mode; active mode leaves clocks running.
// (R10) deep-sleep enable decides deep or ordinary sleep; unit sees which.
// (R11) halt mode gates bus and peripheral clocks once core sleeps.
// (R12) hibernate after deep sleep gates flash power and core clocks.
// (R13) in halt mode deep sleep acts like ordinary sleep.
// (R14) hibernate selected with ordinary sleep keeps active clocking.
// (R15) software sets deep sleep before halt mode with converters running.
// (R16) clock table per mode; slow oscillator and sram always on.
// (R17) regulators, fast oscillator and flash gate follow the mode.
// (R18) any wake returns to active with everything restored.
// (R19) software disables the serial peripheral before stopping its clock.
// (R20) disabling serial peripheral resets its state machine, keeps config.
// (R21) after supply-start, core is held in reset for 18 ms.
// (R22) supply-start reset sets a flag in the reset cause register.
// (R23) corrupt sram is cleared, doubling reset time; else 1.25 ms.
// (R24) key unlock is used by next mode write, lost on a wrong key.
module pmm_top
  import pmm_pkg::*;
#(
  parameter int POR_HOLD = POR_HOLD_CYCLES,
  parameter int RESET_EXIT = RESET_EXIT_CYCLES
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // core sleep signalling and wake
  input wire logic i_core_sleeping,
  input wire logic i_core_sleep_deep,
  input wire logic i_wake,
  // supply monitor and sram check
  input wire logic i_supply_start,
  input wire logic i_sram_corrupt,
  // serial peripheral enable
  input wire logic i_spi_enable,
  // clock gates
  output logic o_undiv_clk_en,
  output logic o_core_clk_en,
  output logic o_conv_clk_en,
  output logic o_membus_clk_en,
  output logic o_periph_clk_en,
  // oscillators, regulators and power gates
  output logic o_fast_osc_en,
  output logic o_fast_osc_low_precision,
  output logic o_slow_osc_en,
  output logic o_high_power_reg_en,
  output logic o_low_power_reg_en,
  output logic o_flash_pwr_en,
  output logic o_sram_pwr_en,
  // resets
  output logic o_core_rst_n,
  output logic o_spi_fsm_clear,
  // sram clearing port
  output logic o_sram_we,
  output logic [SRAM_AW-1:0] o_sram_addr,
  output logic [SRAM_DW-1:0] o_sram_wdata
);
  // ***********************************************
  // apb decode
  // ***********************************************
  logic [2:0] mode_code;
  logic low_prec;
  logic cause_supply;
  pmm_unlock_type unlock;
  pmm_unlock_type next_unlock;
  pmm_power_type pwr;
  pmm_power_type next_pwr;
  pmm_boot_type boot;
  pmm_boot_type next_boot;
  logic boot_armed;
  logic [31:0] next_prdata;

  wire sel_mode = (i_paddr == OFS_MODE);
  wire sel_unlock = (i_paddr == OFS_UNLOCK);
  wire sel_cause = (i_paddr == OFS_CAUSE);
  wire sel_status = (i_paddr == OFS_STATUS);
  wire mapped = sel_mode || sel_unlock || sel_cause || sel_status;
  wire access = i_psel && i_penable;
  wire wr = access && i_pwrite;
  wire setup_rd = i_psel && !i_penable && !i_pwrite;
  wire wr_mode = wr && sel_mode;
  wire wr_unlock = wr && sel_unlock;
  wire wr_cause = wr && sel_cause;
  wire [15:0] key_val = i_pwdata[15:0];
  wire boot_run = (boot == BT_RUN);

  // zero wait states: read data is captured in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = access && !mapped;

  // mode readback returns the stored code
  // (R4) last written code
  wire [7:0] mode_view = {1'b0, low_prec, 3'b000, mode_code};
  wire [2:0] status_view = {boot_run, pwr == PM_HIBERNATE, pwr == PM_HALT};
  assign next_prdata = !setup_rd ? o_prdata :
                       sel_mode ? {24'h00_0000, mode_view} :
                       sel_cause ? {31'h0000_0000, cause_supply} :
                       sel_status ? {29'h0000_0000, status_view} :
                       DATA_ZERO;

  // ***********************************************
  // key protection
  // ***********************************************
  // (R24) single use unlock
  assign next_unlock = wr_mode ? UL_LOCKED :
                       !wr_unlock ? unlock :
                       (key_val == KEY_FIRST) ? UL_FIRST :
                       (unlock == UL_FIRST && key_val == KEY_SECOND) ? UL_OPEN :
                       UL_LOCKED;
  // (R3) keys gate the write
  wire mode_take = wr_mode && (unlock == UL_OPEN);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_prdata <= DATA_ZERO;
      unlock <= UL_LOCKED;
    end
    else
    begin
      o_prdata <= next_prdata;
      unlock <= next_unlock;
    end
  end

  // ***********************************************
  // mode register
  // ***********************************************
  // reserved bits are dropped, so they always read zero
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      // (R7) reset to active
      mode_code <= MODE_RESET[CODE_MSB:CODE_LSB];
      low_prec <= MODE_RESET[BIT_LOW_PREC];
    end
    else if (mode_take)
    begin
      // (R6) reserved bits dropped
      mode_code <= i_pwdata[CODE_MSB:CODE_LSB];
      // (R5) precision select
      low_prec <= i_pwdata[BIT_LOW_PREC];
    end
  end

  // ***********************************************
  // power mode sequencing
  // ***********************************************
  // (R10) deep versus ordinary sleep
  // (R1) halt code on sleep
  wire want_halt = i_core_sleeping && (mode_code == CODE_HALT);
  // (R2) hibernate code on deep sleep
  wire want_hib = i_core_sleeping && i_core_sleep_deep && (mode_code == CODE_HIB);

  always_comb
  begin
    next_pwr = pwr;
    case (pwr)
      PM_ACTIVE:
      begin
        // (R13) deep sleep same as sleep in halt
        if (boot_run && want_halt)
          next_pwr = PM_HALT;
        // (R14) shallow sleep never hibernates
        else if (boot_run && want_hib)
          next_pwr = PM_HIBERNATE;
      end
      PM_HALT, PM_HIBERNATE:
      begin
        // (R18) wake restores active
        if (i_wake || !i_core_sleeping || !boot_run)
          next_pwr = PM_ACTIVE;
      end
      default:
        next_pwr = PM_ACTIVE;
    endcase
  end

  // gates come from the next state so they switch with the mode
  // (R16) clock table
  wire nx_hib = (next_pwr == PM_HIBERNATE);
  wire nx_bus_on = (next_pwr == PM_ACTIVE);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      pwr <= PM_ACTIVE;
      o_undiv_clk_en <= 1'b1;
      o_core_clk_en <= 1'b1;
      o_conv_clk_en <= 1'b1;
      o_membus_clk_en <= 1'b1;
      o_periph_clk_en <= 1'b1;
      o_fast_osc_en <= 1'b1;
      o_high_power_reg_en <= 1'b1;
      o_low_power_reg_en <= 1'b0;
      o_flash_pwr_en <= 1'b1;
    end
    else
    begin
      pwr <= next_pwr;
      // (R8) active gates nothing
      // (R9) core sleeps, clocks run in active
      // (R11) halt gates bus and peripheral only
      o_undiv_clk_en <= !nx_hib;
      o_core_clk_en <= !nx_hib;
      o_conv_clk_en <= !nx_hib;
      o_membus_clk_en <= nx_bus_on;
      o_periph_clk_en <= nx_bus_on;
      // (R17) regulator and oscillator switching
      o_fast_osc_en <= !nx_hib;
      o_high_power_reg_en <= !nx_hib;
      o_low_power_reg_en <= nx_hib;
      // (R12) flash power gate
      o_flash_pwr_en <= !nx_hib;
    end
  end

  // ***********************************************
  // always-on outputs, oscillator precision and serial peripheral
  // ***********************************************
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_slow_osc_en <= 1'b1;
      o_sram_pwr_en <= 1'b1;
      o_fast_osc_low_precision <= 1'b0;
      o_spi_fsm_clear <= 1'b1;
    end
    else
    begin
      o_slow_osc_en <= 1'b1;
      o_sram_pwr_en <= 1'b1;
      o_fast_osc_low_precision <= low_prec;
      // (R20) disable clears fsm only
      o_spi_fsm_clear <= !i_spi_enable;
    end
  end

  // ***********************************************
  // supply-start reset sequence
  // ***********************************************
  logic cnt_done;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;

  wire [CNT_W-1:0] hold_len = CNT_W'(POR_HOLD);
  wire [CNT_W-1:0] exit_len = CNT_W'(RESET_EXIT);
  // (R23) clearing doubles the exit time
  wire [CNT_W-1:0] init_len = i_sram_corrupt ? {exit_len[CNT_W-2:0], 1'b0} : exit_len;
  wire hold_launch = (boot == BT_HOLD) && !boot_armed && !i_supply_start;
  wire init_launch = (boot == BT_HOLD) && boot_armed && cnt_done && !i_supply_start;

  assign cnt_load = hold_launch || init_launch;
  assign cnt_value = hold_launch ? hold_len : init_len;

  always_comb
  begin
    next_boot = boot;
    case (boot)
      BT_HOLD:
        if (init_launch)
          next_boot = BT_INIT;
      BT_INIT:
        if (cnt_done)
          next_boot = BT_RUN;
      BT_RUN:
        next_boot = BT_RUN;
      default:
        next_boot = BT_HOLD;
    endcase
    if (i_supply_start)
      next_boot = BT_HOLD;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      boot <= BT_HOLD;
      boot_armed <= 1'b0;
      o_core_rst_n <= 1'b0;
    end
    else
    begin
      boot <= next_boot;
      boot_armed <= (next_boot == BT_HOLD) && (boot_armed || hold_launch);
      // (R21) core held until run
      o_core_rst_n <= (next_boot == BT_RUN);
    end
  end

  // power-up counts as a supply start; set wins over clear
  // (R22) supply-start cause flag
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      cause_supply <= 1'b1;
    else if (i_supply_start)
      cause_supply <= 1'b1;
    else if (wr_cause && i_pwdata[BIT_CAUSE_SUPPLY])
      cause_supply <= 1'b0;
  end

  pmm_delay_counter u_delay
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_load(cnt_load),
    .i_load_value(cnt_value),
    .o_busy(),
    .o_done(cnt_done)
  );

  pmm_sram_clear u_clear
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(init_launch && i_sram_corrupt),
    .o_we(o_sram_we),
    .o_addr(o_sram_addr),
    .o_wdata(o_sram_wdata)
  );

  // ***********************************************
  // assertions
  // ***********************************************
  a_key_locked_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R3
    wr_mode && unlock != UL_OPEN |=> $stable(mode_code) && $stable(low_prec))
    else $error("mode changed without keys");

  a_key_open_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R1
    mode_take |=> mode_code == $past(i_pwdata[2:0]) && unlock == UL_LOCKED)
    else $error("unlocked mode write not stored");

  a_unlock_two_keys: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R24
    wr_unlock && key_val != KEY_FIRST && key_val != KEY_SECOND |=> unlock == UL_LOCKED)
    else $error("wrong key kept unlock");

  a_mode_readback: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R4
    access && !i_pwrite && sel_mode && $past(setup_rd) |-> o_prdata[7:0] == mode_view)
    else $error("mode readback mismatch");

  a_reset_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R7
    $rose(i_rst_n) |-> mode_code == CODE_ACTIVE && !low_prec && pwr == PM_ACTIVE)
    else $error("mode register reset value wrong");

  a_precision_out: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R5
    ##1 o_fast_osc_low_precision == $past(low_prec))
    else $error("precision output not following bit 6");

  a_active_clocks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R8
    pwr == PM_ACTIVE |-> o_membus_clk_en && o_periph_clk_en && o_core_clk_en
      && o_conv_clk_en && o_undiv_clk_en && !o_low_power_reg_en)
    else $error("clock gated in active mode");

  a_halt_gating: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R11
    pwr == PM_HALT |-> !o_membus_clk_en && !o_periph_clk_en && o_core_clk_en
      && o_high_power_reg_en && o_flash_pwr_en)
    else $error("halt mode gating wrong");

  a_hib_power: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R12
    pwr == PM_HIBERNATE |-> !o_core_clk_en && !o_flash_pwr_en && !o_high_power_reg_en
      && o_low_power_reg_en && !o_fast_osc_en && o_sram_pwr_en && o_slow_osc_en)
    else $error("hibernate gating wrong");

  a_deep_in_halt: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R13
    pwr == PM_ACTIVE && boot_run && i_core_sleeping && i_core_sleep_deep
      && mode_code == CODE_HALT |=> pwr == PM_HALT)
    else $error("deep sleep in halt mode not halting");

  a_shallow_no_hib: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R14
    pwr == PM_ACTIVE && i_core_sleeping && !i_core_sleep_deep
      && mode_code == CODE_HIB |=> pwr == PM_ACTIVE && o_membus_clk_en)
    else $error("ordinary sleep entered hibernate");

  a_wake_return: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R18
    pwr != PM_ACTIVE && i_wake |=> pwr == PM_ACTIVE && o_core_clk_en && o_flash_pwr_en)
    else $error("wake did not restore active");

  a_por_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R21
    i_supply_start |=> !o_core_rst_n [*8])
    else $error("core released too early");

  a_por_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R22
    i_supply_start |=> cause_supply)
    else $error("supply-start flag not set");

  a_scrub_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R23
    o_sram_we |-> o_sram_wdata == SRAM_CLEAR && !o_core_rst_n)
    else $error("sram clear outside reset or nonzero");
endmodule // pmm_top

// ===== sim/pmm_core_model.sv
/*
  pmm_core_model: behavioural processor core at the sleep link.
  assumes the bench asks for a wait-for-interrupt or a wake one cycle at a time.
*/
`timescale 1ns/10ps
module pmm_core_model
(
  // clock
  input wire logic i_clk_sys,
  // bench control
  input wire logic i_wfi,
  input wire logic i_deep_en,
  input wire logic i_wake_req,
  // sleep signalling
  output logic o_sleeping,
  output logic o_deep,
  output logic o_wake
);
  initial
  begin
    o_sleeping = 1'b0;
    o_deep = 1'b0;
    o_wake = 1'b0;
  end
  // ***********************************************
  // sleep and wake
  // ***********************************************
  always @(posedge i_clk_sys)
  begin
    o_wake <= i_wake_req;
    if (i_wake_req)
    begin
      o_sleeping <= 1'b0;
      o_deep <= 1'b0;
    end
    else if (i_wfi)
    begin
      o_sleeping <= 1'b1;
      o_deep <= i_deep_en;
    end
  end
endmodule // pmm_core_model

// ===== sim/tb_top.sv
/*
  tb_top: apb-driven bench of the power mode manager with a core model.
  assumes short boot counts; o_pready may answer at any access edge.
*/
`timescale 1ns/10ps
module tb_top;
  import pmm_pkg::*;
  localparam int PH = 20;
  // doubled exit count must outlast the 1024-word sram sweep
  localparam int RE = 600;
  // order: undiv core conv membus periph fosc hpreg lpreg flash slow sram
  localparam logic [10:0] G_ACT = 11'h7f7;
  localparam logic [10:0] G_HALT = 11'h737;
  localparam logic [10:0] G_HIB = 11'h00b;
  logic clk = 1'b0, rst_n = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic o_pready, o_pslverr, e, sl, dp, wk, wfi = 1'b0, deep_en = 1'b0, wreq = 1'b0;
  logic sup = 1'b0, corrupt = 1'b0, spi_en = 1'b1, rstc_n, fsm_clr, swe, swe_seen, lowp;
  logic [10:0] g;
  logic [SRAM_AW-1:0] saddr, la;
  logic [SRAM_DW-1:0] swd;
  int error_cnt = 0, n_checks = 0, n, nw;
  logic [2:0] codes [5] = '{CODE_ACTIVE, CODE_HALT, CODE_HALT, CODE_HIB, CODE_HIB};
  logic deeps [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [10:0] gexp [5] = '{G_ACT, G_HALT, G_HALT, G_ACT, G_HIB};
  logic [2:0] sexp [5] = '{3'h4, 3'h5, 3'h5, 3'h4, 3'h6};
  always #2.5 clk = ~clk;
  pmm_core_model core (.i_clk_sys(clk), .i_wfi(wfi), .i_deep_en(deep_en),
    .i_wake_req(wreq), .o_sleeping(sl), .o_deep(dp), .o_wake(wk));
  pmm_top #(.POR_HOLD(PH), .RESET_EXIT(RE)) uut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_core_sleeping(sl), .i_core_sleep_deep(dp), .i_wake(wk), .i_supply_start(sup),
    .i_sram_corrupt(corrupt), .i_spi_enable(spi_en), .o_undiv_clk_en(g[10]),
    .o_core_clk_en(g[9]), .o_conv_clk_en(g[8]), .o_membus_clk_en(g[7]),
    .o_periph_clk_en(g[6]), .o_fast_osc_en(g[5]), .o_fast_osc_low_precision(lowp),
    .o_slow_osc_en(g[1]), .o_high_power_reg_en(g[4]), .o_low_power_reg_en(g[3]),
    .o_flash_pwr_en(g[2]), .o_sram_pwr_en(g[0]), .o_core_rst_n(rstc_n),
    .o_spi_fsm_clear(fsm_clr), .o_sram_we(swe), .o_sram_addr(saddr), .o_sram_wdata(swd));
  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge clk);
    i_penable <= 1'b1;
    @(posedge clk);
    while (o_pready !== 1'b1 && t < 50)
    begin
      @(posedge clk);
      t++;
    end
    check("pready", o_pready, 1'b1);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic set_mode(input logic [31:0] d);
    // both keys before each mode write
    apb(1'b1, OFS_UNLOCK, {16'h0, KEY_FIRST});
    apb(1'b1, OFS_UNLOCK, {16'h0, KEY_SECOND});
    apb(1'b1, OFS_MODE, d);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic boot(input int lo, input int hi);
    n = 0;
    nw = 0;
    la = '0;
    swe_seen = 1'b0;
    while (rstc_n !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      swe_seen = swe_seen | (swe === 1'b1);
      if (swe === 1'b1)
        la = saddr;
      nw = nw + (swe === 1'b1);
      n++;
    end
    check("boot_len", (n >= lo && n <= hi), 1);
    check("sram_sweep", swe_seen, corrupt);
    check("sram_words", nw, corrupt ? SRAM_LAST + 1 : 0);
    check("sram_last", la, corrupt ? SRAM_LAST : '0);
    check("sram_zero", swd == '0, 1'b1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    cyc(20000);
    error_cnt++;
    end_of_test();
  end
  // ***********************************************
  // tests
  // ***********************************************
  initial
  begin
    cyc(20);
    rst_n <= 1'b1;
    boot(PH + RE, PH + RE + 4);
    apb(1'b0, OFS_MODE, 0);
    check("mode_rst", q, {24'h0, MODE_RESET});
    check("gates_rst", {lowp, g}, {1'b0, G_ACT});
    apb(1'b0, OFS_CAUSE, 0);
    check("cause_por", q[0], 1'b1);
    apb(1'b1, OFS_CAUSE, 32'h1);
    apb(1'b0, OFS_CAUSE, 0);
    check("cause_clr", q[0], 1'b0);
    apb(1'b0, 12'h010, 0);
    check("unmapped_rd", q, 32'h0);
    check("unmapped_err", e, 1'b1);
    $display("test reset done");
    apb(1'b1, OFS_MODE, 32'h43);
    apb(1'b0, OFS_MODE, 0);
    check("no_key", q, 32'h0);
    set_mode(32'h43);
    apb(1'b0, OFS_MODE, 0);
    check("mode_rd", q, 32'h43);
    check("low_prec", lowp, 1'b1);
    apb(1'b1, OFS_MODE, 32'h05);
    apb(1'b0, OFS_MODE, 0);
    check("key_used", q, 32'h43);
    apb(1'b1, OFS_UNLOCK, {16'h0, KEY_FIRST});
    apb(1'b1, OFS_UNLOCK, 32'h1234);
    apb(1'b1, OFS_UNLOCK, {16'h0, KEY_SECOND});
    apb(1'b1, OFS_MODE, 32'h05);
    apb(1'b0, OFS_MODE, 0);
    check("key_wrong", q, 32'h43);
    $display("test unlock done");
    // serial peripheral off before clock stops
    spi_en <= 1'b0;
    cyc(3);
    check("spi_clear", fsm_clr, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      set_mode({29'h0, codes[i]});
      // deep enable as the case needs
      deep_en <= deeps[i];
      wfi <= 1'b1;
      cyc(1);
      wfi <= 1'b0;
      cyc(4);
      check("gates_sleep", g, gexp[i]);
      apb(1'b0, OFS_STATUS, 0);
      check("status", q[2:0], sexp[i]);
      apb(1'b0, OFS_MODE, 0);
      check("code_rd", q[2:0], codes[i]);
      wreq <= 1'b1;
      cyc(1);
      wreq <= 1'b0;
      cyc(4);
      check("gates_wake", g, G_ACT);
    end
    spi_en <= 1'b1;
    cyc(3);
    check("spi_run", fsm_clr, 1'b0);
    $display("test sleep done");
    corrupt <= 1'b1;
    sup <= 1'b1;
    cyc(1);
    sup <= 1'b0;
    cyc(2);
    check("core_held", rstc_n, 1'b0);
    boot(PH + 2 * RE - 2, PH + 2 * RE + 4);
    apb(1'b0, OFS_CAUSE, 0);
    check("cause_sup", q[0], 1'b1);
    $display("test supply done");
    end_of_test();
  end
endmodule // tb_top
